// File: eih_far_end.sv
// far-side model: interrupt sources and an alternate bus master
`timescale 1ns/1ps
module eih_far_end (
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic [3:0] irq_fire,
	input  wire logic [2:0] irq_len,
	input  wire logic       hold_want,
	output logic      [3:0] ext_irq_n,
	output logic            hold_req_n
);
	// ********
	// sources
	// ********
	logic [2:0] left [4];
	// a source stays low for irq_len cycles; 1 or 2 gives one recognition
	always_ff @(posedge mclk or negedge nrst) begin
		for (int i = 0; i < 4; i++) begin
			if (!nrst)
				left[i] <= 3'h0;
			else if (irq_fire[i])
				left[i] <= irq_len;
			else if (left[i] != 3'h0)
				left[i] <= left[i] - 3'h1;
		end
	end
	always_comb begin
		for (int i = 0; i < 4; i++)
			ext_irq_n[i] = (left[i] == 3'h0);
	end
	// the master asks as a plain level, with no regard to the clock
	assign hold_req_n = !hold_want;
endmodule : eih_far_end

// File: eih_pkg.sv
// constants and types for the external interrupt and bus hold block
package eih_pkg;
	localparam int unsigned IRQ_COUNT     = 4;
	localparam int unsigned SYNC_STAGES   = 2;
	localparam int unsigned CLK_PERIOD_NS = 5;
	// least spacing between two accepted requests on one input, in cycles
	localparam int unsigned IRQ_SPACING   = 2;
	localparam logic [3:0]  IRQ_NONE      = 4'h0;
	localparam logic        LVL_HI        = 1'h1;
	localparam logic        LVL_LO        = 1'h0;

	typedef enum logic [3:0] {
		EIH_IDLE   = 4'h1,
		EIH_PARK   = 4'h2,
		EIH_HELD   = 4'h4,
		EIH_EXIT   = 4'h8
	} eih_hold_t;
endpackage : eih_pkg

// File: eih_top.sv
// external interrupt sampling, acknowledge strobe and primary bus hold logic
`timescale 1ns/1ps
module eih_top (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic [3:0]  ext_irq_n,
	input  wire logic        fetch_boundary,
	input  wire logic        ack_decode_start,
	input  wire logic        hold_req_n,
	input  wire logic        hold_ignore_bit,
	input  wire logic        core_strobe_n,
	input  wire logic        bus_read_req,
	input  wire logic        bus_write_req,
	output logic [3:0]       irq_dispatch,
	output logic [3:0]       irq_pending,
	output logic             irq_ack_strobe_n,
	output logic             bus_release_grant_n,
	output logic             bus_strobe_n,
	output logic             bus_strobe_oe,
	output logic             bus_rw_oe,
	output logic             bus_addr_oe,
	output logic             bus_data_oe,
	output logic             core_stall,
	output logic             write_parked
);

	// ************************************************************
	// input synchronisers
	// ************************************************************
	logic [3:0] irq_meta;
	logic [3:0] irq_sync_n;
	logic       hold_meta;
	logic       hold_sync_n;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_meta    <= ~eih_pkg::IRQ_NONE;
			irq_sync_n  <= ~eih_pkg::IRQ_NONE;
			hold_meta   <= eih_pkg::LVL_HI;
			hold_sync_n <= eih_pkg::LVL_HI;
		end else begin
			// the first stage feeds only the second stage
			irq_meta    <= ext_irq_n;
			irq_sync_n  <= irq_meta;
			hold_meta   <= hold_req_n;
			hold_sync_n <= hold_meta;
		end
	end

	// ************************************************************
	// interrupt detection and dispatch
	// ************************************************************
	// a level held across two sample edges is counted once: after an
	// accept the next sample of that input is ignored
	logic [3:0] irq_lockout;
	logic [3:0] irq_accept;
	assign irq_accept = ~irq_sync_n & ~irq_lockout;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_lockout <= eih_pkg::IRQ_NONE;
		end else begin
			irq_lockout <= irq_accept;
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_pending <= eih_pkg::IRQ_NONE;
		end else if (fetch_boundary) begin
			// a fresh accept in the hand-off cycle wins over the clear
			irq_pending <= irq_accept;
		end else begin
			irq_pending <= irq_pending | irq_accept;
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_dispatch <= eih_pkg::IRQ_NONE;
		end else if (fetch_boundary) begin
			irq_dispatch <= irq_pending;
		end else begin
			irq_dispatch <= eih_pkg::IRQ_NONE;
		end
	end

	// ************************************************************
	// interrupt acknowledge strobe
	// ************************************************************
	// only the start of decode is seen, so a stretched decode cannot
	// widen the strobe
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_ack_strobe_n <= eih_pkg::LVL_HI;
		end else begin
			irq_ack_strobe_n <= ~ack_decode_start;
		end
	end
	// ************************************************************
	// hold state machine
	// ************************************************************
	eih_pkg::eih_hold_t state;
	eih_pkg::eih_hold_t next_state;
	logic               hold_want;
	// the synchroniser adds the late-sample cycle allowed for hold
	assign hold_want = !hold_sync_n && !hold_ignore_bit;
	always_comb begin
		next_state = state;
		case (state)
			eih_pkg::EIH_IDLE: begin
				if (hold_want) begin
					next_state = eih_pkg::EIH_PARK;
				end
			end
			eih_pkg::EIH_PARK: begin
				next_state = hold_ignore_bit ? eih_pkg::EIH_IDLE
				                             : eih_pkg::EIH_HELD;
			end
			eih_pkg::EIH_HELD: begin
				if (hold_ignore_bit) begin
					next_state = eih_pkg::EIH_IDLE;
				end else if (hold_sync_n) begin
					next_state = eih_pkg::EIH_EXIT;
				end
			end
			eih_pkg::EIH_EXIT: begin
				next_state = eih_pkg::EIH_IDLE;
			end
			default: begin
				next_state = eih_pkg::EIH_IDLE;
			end
		endcase
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state <= eih_pkg::EIH_IDLE;
		end else begin
			state <= next_state;
		end
	end
	logic next_held;
	logic next_float;
	// grant is low from park through exit: one cycle after release
	assign next_held  = (next_state != eih_pkg::EIH_IDLE);
	assign next_float = (next_state == eih_pkg::EIH_HELD)
	                 || (next_state == eih_pkg::EIH_EXIT);
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bus_release_grant_n <= eih_pkg::LVL_HI;
		end else begin
			bus_release_grant_n <= ~next_held;
		end
	end

	// ************************************************************
	// bus pin drive
	// ************************************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bus_strobe_n  <= eih_pkg::LVL_HI;
			bus_strobe_oe <= eih_pkg::LVL_HI;
			bus_rw_oe     <= eih_pkg::LVL_LO;
			bus_addr_oe   <= eih_pkg::LVL_LO;
			bus_data_oe   <= eih_pkg::LVL_LO;
		end else begin
			// strobe high while parked, then float everything
			bus_strobe_n  <= next_held | core_strobe_n;
			bus_strobe_oe <= ~next_float;
			bus_rw_oe     <= ~next_float;
			bus_addr_oe   <= ~next_float;
			bus_data_oe   <= ~next_float & bus_write_req;
		end
	end

	// ************************************************************
	// core stall and parked write
	// ************************************************************
	// a parked write is issued once hold ends; a second write, or any
	// read, must wait for the bus
	logic next_parked;
	always_comb begin
		next_parked = write_parked;
		if (!next_held) begin
			next_parked = eih_pkg::LVL_LO;
		end else if (bus_write_req && !write_parked) begin
			next_parked = eih_pkg::LVL_HI;
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			write_parked <= eih_pkg::LVL_LO;
		end else begin
			write_parked <= next_parked;
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			core_stall <= eih_pkg::LVL_LO;
		end else begin
			core_stall <= next_held
			           && (bus_read_req
			               || (bus_write_req && write_parked));
		end
	end
	// ************************************************************
	// assertions
	// ************************************************************
	property p_sync_delay;
		@(posedge mclk) disable iff (!nrst)
		##2 irq_sync_n == $past(ext_irq_n, 2);
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("irq synchroniser is not two stages");
	property p_accept_spacing;
		@(posedge mclk) disable iff (!nrst)
		(irq_accept[0]) |=> !irq_accept[0];
	endproperty
	a_accept_spacing: assert property (p_accept_spacing)
		else $error("irq accepted on consecutive cycles");
	property p_not_lost;
		@(posedge mclk) disable iff (!nrst)
		(irq_accept[1]) |=> (irq_pending[1] || irq_dispatch[1]);
	endproperty
	a_not_lost: assert property (p_not_lost)
		else $error("accepted irq was dropped");
	property p_dispatch_boundary;
		@(posedge mclk) disable iff (!nrst)
		(irq_dispatch != eih_pkg::IRQ_NONE) |-> $past(fetch_boundary);
	endproperty
	a_dispatch_boundary: assert property (p_dispatch_boundary)
		else $error("irq dispatched off a fetch boundary");
	property p_ack_one_cycle;
		@(posedge mclk) disable iff (!nrst)
		$fell(irq_ack_strobe_n) && !ack_decode_start |=> irq_ack_strobe_n;
	endproperty
	a_ack_one_cycle: assert property (p_ack_one_cycle)
		else $error("ack strobe wider than one cycle");
	property p_ack_start;
		@(posedge mclk) disable iff (!nrst)
		ack_decode_start |=> !irq_ack_strobe_n;
	endproperty
	a_ack_start: assert property (p_ack_start)
		else $error("ack strobe missed decode start");
	property p_grant_follow;
		@(posedge mclk) disable iff (!nrst)
		(!hold_req_n && !hold_ignore_bit)[*5] |-> !bus_release_grant_n;
	endproperty
	a_grant_follow: assert property (p_grant_follow)
		else $error("grant late for held request");
	property p_float_grant;
		@(posedge mclk) disable iff (!nrst)
		!bus_strobe_oe |-> (!bus_release_grant_n && bus_strobe_n
		                    && !bus_rw_oe && !bus_addr_oe);
	endproperty
	a_float_grant: assert property (p_float_grant)
		else $error("bus floated outside a grant");
	property p_park_first;
		@(posedge mclk) disable iff (!nrst)
		$fell(bus_release_grant_n) |-> bus_strobe_oe && bus_strobe_n;
	endproperty
	a_park_first: assert property (p_park_first)
		else $error("strobe not driven high before float");
	property p_ignore;
		@(posedge mclk) disable iff (!nrst)
		hold_ignore_bit [*2] |-> bus_release_grant_n;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("hold granted while ignore bit set");
	property p_stall_cause;
		@(posedge mclk) disable iff (!nrst)
		core_stall |-> !bus_release_grant_n
		            && $past(bus_read_req || bus_write_req);
	endproperty
	a_stall_cause: assert property (p_stall_cause)
		else $error("stall without hold and bus access");
	c_irq_dispatch: cover property (@(posedge mclk) disable iff (!nrst)
		irq_dispatch != eih_pkg::IRQ_NONE);
	c_hold_cycle: cover property (@(posedge mclk) disable iff (!nrst)
		$rose(bus_release_grant_n));
	c_parked: cover property (@(posedge mclk) disable iff (!nrst)
		write_parked && !core_stall);
	c_ack: cover property (@(posedge mclk) disable iff (!nrst)
		$fell(irq_ack_strobe_n));
endmodule : eih_top

// File: ext_irq_and_bus_hold_bench.sv
// self-checking bench for the interrupt and bus hold block
`timescale 1ns/1ps
module ext_irq_and_bus_hold_bench;
	logic        mclk = 1'h0, nrst = 1'h0, prev_g = 1'h1;
	logic [3:0]  ext_irq_n, irq_dispatch, irq_pending, irq_fire = 4'h0;
	logic [2:0]  irq_len = 3'h0;
	logic        fetch_boundary = 1'h0, ack_decode_start = 1'h0;
	logic        hold_want = 1'h0, hold_req_n, hold_ignore_bit = 1'h0;
	logic        core_strobe_n = 1'h0, bus_read_req = 1'h0;
	logic        bus_write_req = 1'h0, irq_ack_strobe_n, core_stall;
	logic        bus_release_grant_n, bus_strobe_n, bus_strobe_oe;
	logic        bus_rw_oe, bus_addr_oe, bus_data_oe, write_parked;
	logic [7:0]  expq [$];
	logic [15:0] rnd = 16'hf623;
	int          n_mismatch = 0, checks_done = 0, cyc = 0;

	always #2.5 mclk = ~mclk;

	eih_far_end far (.mclk, .nrst, .irq_fire, .irq_len, .hold_want,
		.ext_irq_n, .hold_req_n);
	eih_top uut (.mclk, .nrst, .ext_irq_n, .fetch_boundary,
		.ack_decode_start, .hold_req_n, .hold_ignore_bit, .core_strobe_n,
		.bus_read_req, .bus_write_req, .irq_dispatch, .irq_pending,
		.irq_ack_strobe_n, .bus_release_grant_n, .bus_strobe_n,
		.bus_strobe_oe, .bus_rw_oe, .bus_addr_oe, .bus_data_oe,
		.core_stall, .write_parked);

	// ********
	// helpers
	// ********
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic report_and_stop;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	task automatic take(input logic [7:0] got);
		// an event with nothing expected can never match 8'hff
		if (expq.size() == 0)
			check(got, 8'hff);
		else
			check(got, expq.pop_front());
	endtask : take
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	task automatic fire(input int i, input logic [2:0] len, input int n);
		repeat (n) expq.push_back({4'h1, 4'h1 << i});
		irq_fire[i] <= 1'h1;
		irq_len <= len;
		tick(1);
		irq_fire <= 4'h0;
		tick(12);
	endtask : fire

	// ********
	// watcher
	// ********
	always @(negedge mclk) begin
		if (nrst) begin
			if (irq_dispatch !== 4'h0) take({4'h1, irq_dispatch});
			if (irq_ack_strobe_n !== 1'h1) take(8'ha0);
			if (bus_release_grant_n !== prev_g)
				take({7'h30, bus_release_grant_n});
		end
		prev_g = bus_release_grant_n;
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	// ********
	// sequence
	// ********
	initial begin
		tick(3);
		check({5'h0, irq_ack_strobe_n, bus_strobe_n, bus_rw_oe}, 8'h06);
		nrst <= 1'h1;
		fetch_boundary <= 1'h1;
		tick(2);
		for (int i = 0; i < 4; i++) fire(i, 3'h2, 1);
		fire(1, 3'h6, 3);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			fire(int'(rnd[1:0]), rnd[2] ? 3'h2 : 3'h1, 1);
		end
		fetch_boundary <= 1'h0;
		fire(2, 3'h2, 1);
		check({4'h0, irq_pending}, 8'h04);
		check(8'(expq.size()), 8'h01);
		fetch_boundary <= 1'h1;
		expq.push_back(8'ha0);
		ack_decode_start <= 1'h1;
		tick(1);
		ack_decode_start <= 1'h0;
		tick(4);
		expq.push_back(8'h60);
		hold_want <= 1'h1;
		for (int k = 0; k < 8 && bus_release_grant_n !== 1'h0; k++)
			@(negedge mclk);
		check({7'h0, bus_strobe_n}, 8'h01);
		@(negedge mclk);
		check({4'h0, bus_strobe_oe, bus_rw_oe, bus_addr_oe, bus_data_oe},
			8'h00);
		@(posedge mclk);
		bus_read_req <= 1'h1;
		tick(1);
		@(negedge mclk);
		check({7'h0, core_stall}, 8'h01);
		@(posedge mclk);
		bus_read_req <= 1'h0;
		bus_write_req <= 1'h1;
		tick(1);
		bus_write_req <= 1'h0;
		@(negedge mclk);
		check({6'h0, write_parked, core_stall}, 8'h02);
		@(posedge mclk);
		bus_write_req <= 1'h1;
		tick(1);
		bus_write_req <= 1'h0;
		@(negedge mclk);
		check({7'h0, core_stall}, 8'h01);
		@(posedge mclk);
		expq.push_back(8'h61);
		hold_want <= 1'h0;
		tick(3);
		@(negedge mclk);
		check({7'h0, bus_release_grant_n}, 8'h00);
		@(negedge mclk);
		check({5'h0, bus_strobe_oe, bus_rw_oe, bus_addr_oe}, 8'h07);
		check({5'h0, bus_strobe_n, write_parked, bus_data_oe}, 8'h00);
		@(posedge mclk);
		hold_ignore_bit <= 1'h1;
		hold_want <= 1'h1;
		bus_write_req <= 1'h1;
		tick(8);
		check({7'h0, bus_release_grant_n}, 8'h01);
		check({6'h0, bus_data_oe, core_stall}, 8'h02);
		expq.push_back(8'h60);
		hold_ignore_bit <= 1'h0;
		bus_write_req <= 1'h0;
		tick(6);
		expq.push_back(8'h61);
		hold_ignore_bit <= 1'h1;
		tick(1);
		@(negedge mclk);
		check({7'h0, bus_release_grant_n}, 8'h01);
		@(posedge mclk);
		hold_want <= 1'h0;
		tick(4);
		hold_ignore_bit <= 1'h0;
		tick(4);
		check(8'(expq.size()), 8'h00);
		report_and_stop();
	end
endmodule : ext_irq_and_bus_hold_bench
